// file: design/zero_delay_cfg_pll_status.v
// Zero-delay control register and PLL readback status register
//
// Contract
// - Select code 11 routes channel divider 3 into the external feedback path.
// - Codes 00, 01, 10 choose dividers 0, 1, 2; 00 after reset.
// - Mode bit clear with enable set gives internal zero-delay mode; clear at reset.
// - Mode bit set with enable set gives external mode using selected divider.
// - Enable bit turns zero delay on; resets off, mode ignored while off.
// - Status bit 6 reads calibration done; writes have no effect.
// - Status bit 5 reads the holdover level as last captured through the synchroniser.
// - Status bit 4 reads one when the secondary reference drives the loop.
// - Status bit 3 reads one when oscillator frequency is above its threshold.
// - Status bit 2 reads secondary reference above threshold chosen by select bit.
// - Status bit 1 reads primary reference above threshold chosen by select bit.
// - Status bit 0 reads the digital lock detector.
// - Freeze bit set stops status updates and holds the last contents.
`timescale 1ns/100ps
`default_nettype none
`include "zero_delay_defs.vh"

module zero_delay_cfg_pll_status #(
	parameter ADDR_W = `ZD_ADDR_W,
	parameter NSTAT  = 7
) (
	// Clock and reset
	input  wire              clock,
	input  wire              arst_n,
	// Register access port
	input  wire [ADDR_W-1:0] reg_addr,
	input  wire              reg_wr,
	input  wire              reg_rd,
	input  wire [7:0]        reg_wdata,
	output reg  [7:0]        reg_rdata_q,
	output reg               reg_hit_q,
	// Controls held elsewhere in the register map
	input  wire              status_freeze,
	input  wire              threshold_select,
	// Status sources from analog and monitor circuitry
	input  wire              cal_done_in,
	input  wire              holdover_active_in,
	input  wire              secondary_reference_selected_in,
	input  wire              osc_above_threshold_in,
	input  wire              secondary_reference_input_above_thr_in,
	input  wire              primary_reference_input_above_thr_in,
	input  wire              digital_lock_in,
	// Zero-delay controls toward the PLL, threshold select toward the reference monitors
	output reg               zero_delay_on_q,
	output reg               zd_internal_q,
	output reg               zd_external_q,
	output reg  [3:0]        fb_divider_onehot_q,
	output reg               monitor_threshold_select_q
);

	reg  [7:0]       ctrl_q;
	reg  [7:0]       ctrl_d;
	reg  [7:0]       stat_q;
	reg  [7:0]       stat_d;
	wire [NSTAT-1:0] raw_status;
	wire [NSTAT-1:0] sync_status;
	// Captured status word
	wire [7:0]       status_word;
	// Address decode of the current access
	wire             ctrl_wr_hit;
	wire             ctrl_rd_hit;
	wire             stat_rd_hit;
	// Fields of the next control value
	wire             next_enable;
	wire             next_mode;
	wire [1:0]       next_fb_code;
	wire [3:0]       next_fb_route;
	wire [1:0]       next_zd_modes;
	// Word returned by a read
	wire [7:0]       read_word;
	wire             read_hit;

	// Divider code to one-hot feedback route
	function [3:0] fb_decode;
		input [1:0] code;
		begin
			case (code)
				`ZD_FB_DIV0: fb_decode = 4'h1;
				`ZD_FB_DIV1: fb_decode = 4'h2;
				`ZD_FB_DIV2: fb_decode = 4'h4;
				`ZD_FB_DIV3: fb_decode = 4'h8;
				default:     fb_decode = 4'h1;
			endcase
		end
	endfunction

	// Address match against the control register
	function addr_is_ctrl;
		input [ADDR_W-1:0] addr;
		begin
			addr_is_ctrl = (addr == `ZD_CTRL_ADDR);
		end
	endfunction

	// Address match against the status register
	function addr_is_stat;
		input [ADDR_W-1:0] addr;
		begin
			addr_is_stat = (addr == `ZD_STAT_ADDR);
		end
	endfunction

	// Enable and mode bits to {external, internal}; both low while disabled
	function [1:0] zd_modes;
		input enable;
		input mode;
		begin
			zd_modes = 2'b00;
			if (enable)
			begin
				if (mode)
				begin
					zd_modes = 2'b10;
				end
				else
				begin
					zd_modes = 2'b01;
				end
			end
		end
	endfunction

	// Synchronised levels to their status bit positions; bit 7 reads zero
	function [7:0] pack_status;
		input [NSTAT-1:0] levels;
		begin
			pack_status                  = 8'h00;
			pack_status[`ZD_ST_LOCK]     = levels[0];
			pack_status[`ZD_ST_PRI_THR]  = levels[1];
			pack_status[`ZD_ST_SEC_THR]  = levels[2];
			pack_status[`ZD_ST_OSC_THR]  = levels[3];
			pack_status[`ZD_ST_SEC_SEL]  = levels[4];
			pack_status[`ZD_ST_HOLDOVER] = levels[5];
			pack_status[`ZD_ST_CAL_DONE] = levels[6];
		end
	endfunction

	// Read data for an address; unmapped addresses read zero
	function [7:0] read_select;
		input [ADDR_W-1:0] addr;
		input [7:0]        ctrl;
		input [7:0]        stat;
		begin
			if (addr_is_ctrl(addr))
			begin
				read_select = ctrl;
			end
			else if (addr_is_stat(addr))
			begin
				read_select = stat;
			end
			else
			begin
				read_select = `ZD_RDATA_UNMAPPED;
			end
		end
	endfunction

	assign raw_status = {
		cal_done_in,
		holdover_active_in,
		secondary_reference_selected_in,
		osc_above_threshold_in,
		secondary_reference_input_above_thr_in,
		primary_reference_input_above_thr_in,
		digital_lock_in
	};

	status_sync #(
		.WIDTH (NSTAT)
	) u_sync (
		.clock    (clock),
		.arst_n   (arst_n),
		.async_in (raw_status),
		.sync_q   (sync_status)
	);

	// Synchronised levels placed at their status bit positions
	assign status_word = pack_status(sync_status);

	// Which register the current access targets
	assign ctrl_wr_hit = reg_wr & addr_is_ctrl(reg_addr);
	assign ctrl_rd_hit = reg_rd & addr_is_ctrl(reg_addr);
	assign stat_rd_hit = reg_rd & addr_is_stat(reg_addr);
	assign read_hit    = ctrl_rd_hit | stat_rd_hit;
	assign read_word   = read_select(reg_addr, ctrl_q, stat_q);

	// Control register write; unused bits are dropped
	always @*
	begin
		ctrl_d = ctrl_q;
		if (ctrl_wr_hit)
		begin
			ctrl_d = reg_wdata & `ZD_CTRL_WMASK;
		end
	end

	// Fields of the value the control register takes at this edge
	assign next_enable   = ctrl_d[`ZD_EN_BIT];
	assign next_mode     = ctrl_d[`ZD_MODE_BIT];
	assign next_fb_code  = ctrl_d[`ZD_FBSEL_MSB:`ZD_FBSEL_LSB];
	assign next_fb_route = fb_decode(next_fb_code);
	assign next_zd_modes = zd_modes(next_enable, next_mode);

	// Status capture; read-only, writes ignored
	always @*
	begin
		stat_d = stat_q;
		if (!status_freeze)
		begin
			stat_d = status_word;
		end
	end

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_q <= `ZD_CTRL_RESET;
			stat_q <= `ZD_STAT_RESET;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
		end
	end

	// Zero-delay enable and mode toward the PLL
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			zero_delay_on_q <= 1'b0;
			zd_internal_q   <= 1'b0;
			zd_external_q   <= 1'b0;
		end
		else
		begin
			zero_delay_on_q <= next_enable;
			zd_internal_q   <= next_zd_modes[0];
			zd_external_q   <= next_zd_modes[1];
		end
	end

	// Feedback divider route toward the PLL
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fb_divider_onehot_q <= `ZD_FB_ROUTE_RESET;
		end
		else
		begin
			fb_divider_onehot_q <= next_fb_route;
		end
	end

	// Threshold select toward the reference monitors
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			monitor_threshold_select_q <= 1'b0;
		end
		else
		begin
			monitor_threshold_select_q <= threshold_select;
		end
	end

	// Read data, held until the next read
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_rdata_q <= `ZD_RDATA_UNMAPPED;
		end
		else if (reg_rd)
		begin
			reg_rdata_q <= read_word;
		end
	end

	// Read acknowledge, one cycle for a mapped address
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			reg_hit_q <= 1'b0;
		end
		else
		begin
			reg_hit_q <= read_hit;
		end
	end

endmodule

`default_nettype wire

// file: design/zero_delay_defs.vh
// Register offsets, field positions and reset values of the zero-delay and PLL status bank
`ifndef ZERO_DELAY_DEFS_VH
`define ZERO_DELAY_DEFS_VH

`define ZD_ADDR_W          10
`define ZD_CTRL_ADDR       10'h01e
`define ZD_STAT_ADDR       10'h01f
`define ZD_FREEZE_ADDR     10'h01d
`define ZD_THRSEL_ADDR     10'h01a

`define ZD_CTRL_RESET      8'h00
`define ZD_STAT_RESET      8'h00
`define ZD_FB_ROUTE_RESET  4'h1
`define ZD_RDATA_UNMAPPED  8'h00
`define ZD_CTRL_WMASK      8'h1e

`define ZD_EN_BIT          1
`define ZD_MODE_BIT        2
`define ZD_FBSEL_LSB       3
`define ZD_FBSEL_MSB       4
`define ZD_FREEZE_BIT      4
`define ZD_THRSEL_BIT      6

`define ZD_ST_LOCK         0
`define ZD_ST_PRI_THR      1
`define ZD_ST_SEC_THR      2
`define ZD_ST_OSC_THR      3
`define ZD_ST_SEC_SEL      4
`define ZD_ST_HOLDOVER     5
`define ZD_ST_CAL_DONE     6

`define ZD_FB_DIV0         2'h0
`define ZD_FB_DIV1         2'h1
`define ZD_FB_DIV2         2'h2
`define ZD_FB_DIV3         2'h3

`endif

// file: design/status_sync.v
// Two-flop synchroniser for a vector of independent status levels
`timescale 1ns/100ps
`default_nettype none

module status_sync #(
	parameter WIDTH = 7
) (
	// Clock and reset
	input  wire             clock,
	input  wire             arst_n,
	// Levels
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_q
);

	reg [WIDTH-1:0] meta_q;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_q   <= {WIDTH{1'b0}};
			sync_q   <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q   <= async_in;
			sync_q   <= meta_q;
		end
	end

endmodule

`default_nettype wire

// file: tb/zd_checker.sv
// Port assertions for the zero-delay control and status bank
`timescale 1ns/100ps
`default_nettype none
module zd_checker (
	input wire logic       clock,
	input wire logic       arst_n,
	input wire logic [9:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       reg_hit_q,
	input wire logic       status_freeze,
	input wire logic       digital_lock_in,
	input wire logic       zero_delay_on_q,
	input wire logic       zd_internal_q,
	input wire logic       zd_external_q,
	input wire logic [3:0] fb_divider_onehot_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire wc = reg_wr && reg_addr == 10'h01e;
	wire rs = reg_rd && reg_addr == 10'h01f;
	a_sel_onehot: assert property (wc |=> fb_divider_onehot_q == 4'h1 << $past(reg_wdata[4:3]))
		else $error("bad select");
	a_int_mode: assert property (wc |=> zd_internal_q == ($past(reg_wdata[1]) && !$past(reg_wdata[2])))
		else $error("bad internal");
	a_ext_mode: assert property (wc |=> zd_external_q == ($past(reg_wdata[1]) && $past(reg_wdata[2])))
		else $error("bad external");
	a_enable_bit: assert property (wc |=> zero_delay_on_q == $past(reg_wdata[1]))
		else $error("bad enable");
	a_ctrl_hold: assert property (!wc |=> $stable(fb_divider_onehot_q) && $stable(zero_delay_on_q))
		else $error("control moved");
	a_lock_read: assert property ((!status_freeze && $stable(digital_lock_in))[*5] ##0 rs |=> reg_rdata_q[0] == $past(digital_lock_in))
		else $error("bad lock");
	a_freeze_hold: assert property (status_freeze && rs ##1 status_freeze ##1 status_freeze && rs |=> $stable(reg_rdata_q))
		else $error("status moved");
	a_stat_read: assert property (rs |=> reg_hit_q && !reg_rdata_q[7])
		else $error("bad status read");
endmodule
bind zero_delay_cfg_pll_status zd_checker i_chk (.*);
`default_nettype wire

// file: tb/zero_delay_cfg_pll_status_tb.sv
// Self-checking bench for the zero-delay control and status bank
`timescale 1ns/100ps
`default_nettype none
module zero_delay_cfg_pll_status_tb;
	logic clock = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, status_freeze = 0, threshold_select = 0;
	logic [9:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata_q, d;
	logic [6:0] st = 0;
	logic reg_hit_q, zero_delay_on_q, zd_internal_q, zd_external_q, monitor_threshold_select_q;
	logic [3:0] fb_divider_onehot_q;
	int num_errors = 0, checks_done = 0;
	zero_delay_cfg_pll_status i_dut (.*, .cal_done_in(st[6]), .holdover_active_in(st[5]),
		.secondary_reference_selected_in(st[4]), .osc_above_threshold_in(st[3]),
		.secondary_reference_input_above_thr_in(st[2]),
		.primary_reference_input_above_thr_in(st[1]), .digital_lock_in(st[0]));
	initial forever #2 clock = ~clock;
	task automatic chk(input logic [11:0] g, e);
		checks_done++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	// Expected {external, internal, enable, route} for a control word
	function automatic logic [11:0] exp_ctrl(input logic [7:0] v);
		return {5'h0, v[2] & v[1], !v[2] & v[1], v[1], 4'h1 << v[4:3]};
	endfunction
	// One register access; a read is checked against d and hit
	task automatic op(input logic w, h, input logic [9:0] a, input logic [7:0] d);
		@(posedge clock);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
		@(posedge clock);
		{reg_wr, reg_rd} <= 2'b0;
		#1;
		if (!w)
			chk({3'h0, reg_hit_q, reg_rdata_q}, {3'h0, h, d});
	endtask
	task automatic stop_test;
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic settle(input logic [6:0] v);
		@(posedge clock);
		st <= v;
		threshold_select <= v[3];
		repeat (5) @(posedge clock);
	endtask
	initial
	begin
		void'($urandom(32'h31ae));
		repeat (3) @(posedge clock);
		arst_n <= 1;
		op(0, 1, 10'h01e, 8'h00);
		chk({8'h0, fb_divider_onehot_q}, 12'h001);
		for (int i = 0; i < 16; i++)
		begin
			d = 8'($urandom);
			d[4:1] = i[3:0];
			op(1, 0, 10'h01e, d);
			chk({5'h0, zd_external_q, zd_internal_q, zero_delay_on_q, fb_divider_onehot_q},
				exp_ctrl(d));
			op(0, 1, 10'h01e, d & 8'h1e);
		end
		op(0, 0, 10'h000, 8'h00);
		op(1, 0, 10'h01f, 8'hff);
		for (int i = 0; i < 12; i++)
		begin
			settle(i == 0 ? 7'h7f : 7'($urandom));
			op(0, 1, 10'h01f, {1'b0, st});
			chk({11'h0, monitor_threshold_select_q}, {11'h0, threshold_select});
		end
		// A change is not visible before the two-flop stage has passed it
		d = {1'b0, st};
		@(posedge clock);
		st <= ~st;
		@(posedge clock);
		op(0, 1, 10'h01f, d);
		op(0, 1, 10'h01f, {1'b0, st});
		@(posedge clock);
		status_freeze <= 1;
		d = {1'b0, st};
		settle(~st);
		op(0, 1, 10'h01f, d);
		op(0, 1, 10'h01f, d);
		@(posedge clock);
		status_freeze <= 0;
		settle(st);
		op(0, 1, 10'h01f, {1'b0, st});
		stop_test;
	end
endmodule
`default_nettype wire
